// [core/flash_prot_params.svh]
/*
 Timing, geometry and code constants for the flash protection block.
 Assumes inclusion by bare name from the core files.
*/
`ifndef FLASH_PROT_PARAMS_SVH
`define FLASH_PROT_PARAMS_SVH
`define FP_WORDS 32768
`define FP_ADDR_W 15
`define FP_BLOCK_WORDS_LOG2 8
`define FP_PAIR_SHIFT 9
`define FP_NUM_PAIRS 64
`define FP_ERASED_WORD 32'hffffffff
`define FP_RD_LAT 1
`endif

// [core/flash_prot_pkg.sv]
/*
 Types shared by the flash protection block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package flash_prot_pkg;
    typedef enum logic [1:0] {
        PROT_OPEN = 2'h0,
        PROT_READ_ONLY = 2'h1,
        PROT_EXEC_ONLY = 2'h2
    } prot_mode_t;
    typedef enum logic [1:0] {
        MASTER_FETCH = 2'h0,
        MASTER_DATA = 2'h1,
        MASTER_DEBUG = 2'h2
    } master_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ERASE = 3'b010,
        ST_DONE = 3'b100
    } seq_state_t;
endpackage

// [core/prot_lookup_if.sv]
/*
 Interface carrying a pair index to the protection lookup and its verdict back.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface prot_lookup_if;
    import flash_prot_pkg::*;
    logic [5:0] pair;
    prot_mode_t mode;
    modport requester (output pair, input mode);
    modport table_end (input pair, output mode);
endinterface
`default_nettype wire

// [core/prot_table.sv]
/*
 Per-pair protection table: one setting for each 2 KB region.
 Assumes a single clock domain and an async active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
`include "flash_prot_params.svh"
module prot_table
    import flash_prot_pkg::*;
#(
    parameter int NUM_PAIRS = `FP_NUM_PAIRS
)(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic set_en,
    input wire logic [5:0] set_pair,
    input wire prot_mode_t set_mode,
    prot_lookup_if.table_end lk_a,
    prot_lookup_if.table_end lk_b
);
    initial
    begin
        if (NUM_PAIRS != 64)
        begin
            $error("prot_table serves 64 pairs only");
        end
    end
    prot_mode_t mode_q [NUM_PAIRS];
    // One entry per pair, so both blocks of a pair see the same setting
    assign lk_a.mode = mode_q[lk_a.pair];
    assign lk_b.mode = mode_q[lk_b.pair];
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < NUM_PAIRS; i++)
            begin
                mode_q[i] <= PROT_OPEN;
            end
        end
        else if (set_en)
        begin
            mode_q[set_pair] <= set_mode;
        end
    end
endmodule // prot_table
`default_nettype wire

// [core/flash_prot.sv]
/*
 Flash array with per-block erase, word program and per-pair protection.
 Assumes one 50 MHz clock and that requesters hold requests until accepted.
*/
`timescale 1ns/100ps
`default_nettype none
`include "flash_prot_params.svh"
module flash_prot
    import flash_prot_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    input wire logic I_RD_VALID,
    input wire flash_prot_pkg::master_t I_RD_MASTER,
    input wire logic [14:0] I_RD_ADDR,
    output logic O_RD_VALID,
    output logic O_RD_DENIED,
    output logic [31:0] O_RD_DATA,
    input wire logic I_PROG_VALID,
    input wire logic [14:0] I_PROG_ADDR,
    input wire logic [31:0] I_PROG_DATA,
    input wire logic I_ERASE_VALID,
    input wire logic [6:0] I_ERASE_BLOCK,
    output logic O_WR_READY,
    output logic O_WR_DONE,
    output logic O_WR_REFUSED,
    input wire logic I_PROT_SET,
    input wire logic [5:0] I_PROT_PAIR,
    input wire flash_prot_pkg::prot_mode_t I_PROT_MODE
);
    import flash_prot_pkg::*;
    localparam int BW = `FP_BLOCK_WORDS_LOG2;
    logic [31:0] mem [`FP_WORDS];
    seq_state_t st_q, st_d;
    logic [6:0] blk_q;
    logic [BW-1:0] idx_q;
    prot_lookup_if lk_rd ();
    prot_lookup_if lk_wr ();
    prot_table #(.NUM_PAIRS(`FP_NUM_PAIRS)) u_table (
        .clk(I_CLK),
        .arst_n(I_ARST_N),
        .set_en(I_PROT_SET),
        .set_pair(I_PROT_PAIR),
        .set_mode(I_PROT_MODE),
        .lk_a(lk_rd.table_end),
        .lk_b(lk_wr.table_end)
    );
    wire idle = (st_q == ST_IDLE);
    wire prog_go = idle && I_PROG_VALID;
    wire erase_go = idle && !I_PROG_VALID && I_ERASE_VALID;
    // Top address bits name the pair; the low block bit is ignored
    assign lk_rd.pair = I_RD_ADDR[14:9];
    assign lk_wr.pair = I_PROG_VALID ? I_PROG_ADDR[14:9] : I_ERASE_BLOCK[6:1];
    wire wr_locked = (lk_wr.mode == PROT_READ_ONLY) ||
                     (lk_wr.mode == PROT_EXEC_ONLY);
    wire rd_deny = (lk_rd.mode == PROT_EXEC_ONLY) && (I_RD_MASTER != MASTER_FETCH);
    wire prog_ok = prog_go && !wr_locked;
    wire erase_ok = erase_go && !wr_locked;
    wire erase_last = (st_q == ST_ERASE) && (&idx_q);
    assign O_WR_READY = idle;
    always_comb
    begin
        case (st_q)
            ST_IDLE: st_d = erase_ok ? ST_ERASE : ST_IDLE;
            ST_ERASE: st_d = erase_last ? ST_DONE : ST_ERASE;
            ST_DONE: st_d = ST_IDLE;
            default: st_d = ST_IDLE;
        endcase
    end
    always_ff @(posedge I_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            st_q <= ST_IDLE;
            blk_q <= 7'h00;
            idx_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            if (erase_ok)
            begin
                blk_q <= I_ERASE_BLOCK;
            end
            idx_q <= (st_q == ST_ERASE) ? idx_q + 1'b1 : '0;
        end
    end
    // Array has no reset; one write port, erase walks one word per clock
    always_ff @(posedge I_CLK)
    begin
        if (st_q == ST_ERASE)
        begin
            mem[{blk_q, idx_q}] <= `FP_ERASED_WORD;
        end
        else if (prog_ok)
        begin
            // Flash programming only clears bits
            mem[I_PROG_ADDR] <= mem[I_PROG_ADDR] & I_PROG_DATA;
        end
    end
    logic [31:0] rdata;
    assign rdata = mem[I_RD_ADDR];
    always_ff @(posedge I_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            O_RD_VALID <= 1'b0;
            O_RD_DENIED <= 1'b0;
            O_RD_DATA <= 32'h00000000;
            O_WR_DONE <= 1'b0;
            O_WR_REFUSED <= 1'b0;
        end
        else
        begin
            O_RD_VALID <= I_RD_VALID;
            O_RD_DENIED <= I_RD_VALID && rd_deny;
            // Denied reads return zero so nothing leaks
            O_RD_DATA <= (I_RD_VALID && !rd_deny) ? rdata : 32'h00000000;
            O_WR_DONE <= prog_ok || (st_q == ST_DONE);
            O_WR_REFUSED <= (prog_go || erase_go) && wr_locked;
        end
    end
    property p_rd_one;
        @(posedge I_CLK) disable iff (!I_ARST_N) I_RD_VALID |=> O_RD_VALID;
    endproperty
    a_rd_one: assert property (p_rd_one) else $error("read not answered next cycle");
    property p_exec_deny;
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (I_RD_VALID && lk_rd.mode == PROT_EXEC_ONLY && I_RD_MASTER != MASTER_FETCH)
        |=> (O_RD_DENIED && O_RD_DATA == 32'h00000000);
    endproperty
    a_exec_deny: assert property (p_exec_deny) else $error("exec-only read leaked");
    property p_fetch_ok;
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (I_RD_VALID && I_RD_MASTER == MASTER_FETCH) |=> !O_RD_DENIED;
    endproperty
    a_fetch_ok: assert property (p_fetch_ok) else $error("fetch denied");
    property p_ro_refuse;
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (prog_go && lk_wr.mode == PROT_READ_ONLY) |=> (O_WR_REFUSED && !O_WR_DONE);
    endproperty
    a_ro_refuse: assert property (p_ro_refuse) else $error("read-only write taken");
    property p_xo_refuse;
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (erase_go && lk_wr.mode == PROT_EXEC_ONLY) |=> (O_WR_REFUSED && st_q == ST_IDLE);
    endproperty
    a_xo_refuse: assert property (p_xo_refuse) else $error("exec-only erase started");
    property p_erase_len;
        @(posedge I_CLK) disable iff (!I_ARST_N)
        erase_ok |=> (st_q == ST_ERASE) [*8] ##249 (st_q == ST_DONE);
    endproperty
    a_erase_len: assert property (p_erase_len) else $error("erase length wrong");
    property p_erase_ones;
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (st_q == ST_ERASE) |=> (mem[$past({blk_q, idx_q})] == `FP_ERASED_WORD);
    endproperty
    a_erase_ones: assert property (p_erase_ones) else $error("erased word not ones");
    property p_pair_same;
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (I_PROG_VALID && I_PROG_ADDR[14:9] == I_RD_ADDR[14:9]) |-> (lk_wr.mode == lk_rd.mode);
    endproperty
    a_pair_same: assert property (p_pair_same) else $error("pair setting split");
    property p_pair_idx;
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (!I_PROG_VALID) |-> (lk_wr.pair == I_ERASE_BLOCK[6:1]);
    endproperty
    a_pair_idx: assert property (p_pair_idx) else $error("pair index wrong");
endmodule // flash_prot
`default_nettype wire

// [tb/flash_requester.sv]
/*
 Far-side requester: instruction fetch, data and debug reads, program, erase, protection set.
 Assumes the block samples on the rising edge; this side drives on the falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module flash_requester
    import flash_prot_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_wr_ready,
    input wire logic i_wr_done,
    input wire logic i_wr_refused,
    output logic o_rd_valid,
    output var flash_prot_pkg::master_t o_rd_master,
    output logic [14:0] o_rd_addr,
    output logic o_prog_valid,
    output logic [14:0] o_prog_addr,
    output logic [31:0] o_prog_data,
    output logic o_erase_valid,
    output logic [6:0] o_erase_block,
    output logic o_prot_set,
    output logic [5:0] o_prot_pair,
    output var flash_prot_pkg::prot_mode_t o_prot_mode
);
    initial
    begin
        {o_rd_valid, o_prog_valid, o_erase_valid, o_prot_set} = 4'h0;
        {o_rd_addr, o_prog_addr, o_prog_data, o_erase_block, o_prot_pair} = '0;
        o_rd_master = MASTER_FETCH;
        o_prot_mode = PROT_OPEN;
    end
    task automatic rd(input master_t m, input logic [14:0] a);
        @(negedge i_clk);
        o_rd_valid = 1'h1;
        o_rd_master = m;
        o_rd_addr = a;
        @(negedge i_clk);
        o_rd_valid = 1'h0;
        // Idle address flips so a stale address is never mistaken for a held one
        o_rd_addr = ~a;
    endtask
    // Ready only moves on a rising edge, so seen high here it still stands at the next one
    task automatic wr(input logic er, input logic [14:0] a, input logic [31:0] d,
        output logic done, output logic refused, output logic busy);
        int n;
        n = 0;
        @(negedge i_clk);
        while (!i_wr_ready && n < 300)
        begin
            @(negedge i_clk);
            n++;
        end
        n = 0;
        o_prog_valid = !er;
        o_erase_valid = er;
        o_prog_addr = a;
        o_erase_block = a[14:8];
        o_prog_data = d;
        @(negedge i_clk);
        o_prog_valid = 1'h0;
        o_erase_valid = 1'h0;
        o_prog_data = ~d;
        busy = !i_wr_ready;
        while (!(i_wr_done || i_wr_refused) && n < 300)
        begin
            @(negedge i_clk);
            n++;
        end
        done = i_wr_done;
        refused = i_wr_refused;
    endtask
    task automatic prot(input logic [5:0] p, input prot_mode_t m);
        @(negedge i_clk);
        o_prot_set = 1'h1;
        o_prot_pair = p;
        o_prot_mode = m;
        @(negedge i_clk);
        o_prot_set = 1'h0;
    endtask
endmodule // flash_requester
`default_nettype wire

// [tb/tb.sv]
/*
 Self-checking bench for the flash protection block.
 Assumes the requester model on the far side and a 50 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
    import flash_prot_pkg::*;
    logic clk = 1'h0;
    logic arst_n = 1'h0;
    logic rv, rvo, rdn, pv, ev, wrdy, wdone, wref, ps;
    master_t rm;
    prot_mode_t pm;
    logic [14:0] ra, pa;
    logic [31:0] rdo, pd;
    logic [6:0] eb;
    logic [5:0] pp;
    logic dn, rf, bz;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    flash_prot DUT (.I_CLK(clk), .I_ARST_N(arst_n), .I_RD_VALID(rv), .I_RD_MASTER(rm),
        .I_RD_ADDR(ra), .O_RD_VALID(rvo), .O_RD_DENIED(rdn), .O_RD_DATA(rdo),
        .I_PROG_VALID(pv), .I_PROG_ADDR(pa), .I_PROG_DATA(pd), .I_ERASE_VALID(ev),
        .I_ERASE_BLOCK(eb), .O_WR_READY(wrdy), .O_WR_DONE(wdone), .O_WR_REFUSED(wref),
        .I_PROT_SET(ps), .I_PROT_PAIR(pp), .I_PROT_MODE(pm));
    flash_requester far (.i_clk(clk), .i_wr_ready(wrdy), .i_wr_done(wdone), .i_wr_refused(wref),
        .o_rd_valid(rv), .o_rd_master(rm), .o_rd_addr(ra), .o_prog_valid(pv),
        .o_prog_addr(pa), .o_prog_data(pd), .o_erase_valid(ev), .o_erase_block(eb),
        .o_prot_set(ps), .o_prot_pair(pp), .o_prot_mode(pm));
    always #10 clk = ~clk;
    // Three erases of about 260 cycles each plus short traffic fit well inside this
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            fails++;
            conclude();
        end
    end
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_flag(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic rd_chk(input master_t m, input logic [14:0] a, input logic [31:0] d,
        input logic deny);
        far.rd(m, a);
        chk_flag("rd_denied", deny, rdn);
        chk_word("rd_data", deny ? 32'h0 : d, rdo);
        chk_flag("rd_valid", 1'h1, rvo);
    endtask
    task automatic wr_chk(input logic er, input logic [14:0] a, input logic [31:0] d,
        input logic refuse);
        far.wr(er, a, d, dn, rf, bz);
        chk_flag("wr_done", !refuse, dn);
        chk_flag("wr_refused", refuse, rf);
        chk_flag("wr_busy", er && !refuse, bz);
        chk_flag("wr_ready", 1'h1, wrdy);
    endtask
    task automatic test_erase();
        wr_chk(1'h1, 15'h0200, 32'h0, 1'h0);
        rd_chk(MASTER_DATA, 15'h0200, 32'hffffffff, 1'h0);
        rd_chk(MASTER_DEBUG, 15'h02ff, 32'hffffffff, 1'h0);
        $display("test erase finished");
    endtask
    task automatic test_program();
        wr_chk(1'h0, 15'h0210, 32'h12345678, 1'h0);
        rd_chk(MASTER_DATA, 15'h0210, 32'h12345678, 1'h0);
        wr_chk(1'h1, 15'h0300, 32'h0, 1'h0);
        rd_chk(MASTER_DATA, 15'h0210, 32'h12345678, 1'h0);
        rd_chk(MASTER_FETCH, 15'h03ff, 32'hffffffff, 1'h0);
        $display("test program finished");
    endtask
    task automatic test_read_only();
        far.prot(6'h01, PROT_READ_ONLY);
        wr_chk(1'h0, 15'h0300, 32'h0, 1'h1);
        wr_chk(1'h1, 15'h0200, 32'h0, 1'h1);
        rd_chk(MASTER_DATA, 15'h0210, 32'h12345678, 1'h0);
        rd_chk(MASTER_DEBUG, 15'h0300, 32'hffffffff, 1'h0);
        wr_chk(1'h1, 15'h0400, 32'h0, 1'h0);
        $display("test read-only finished");
    endtask
    task automatic test_exec_only();
        far.prot(6'h01, PROT_EXEC_ONLY);
        wr_chk(1'h1, 15'h0300, 32'h0, 1'h1);
        wr_chk(1'h0, 15'h0210, 32'h0, 1'h1);
        rd_chk(MASTER_FETCH, 15'h0210, 32'h12345678, 1'h0);
        rd_chk(MASTER_DATA, 15'h0210, 32'h0, 1'h1);
        rd_chk(MASTER_DEBUG, 15'h0300, 32'h0, 1'h1);
        rd_chk(MASTER_DEBUG, 15'h0400, 32'hffffffff, 1'h0);
        $display("test exec-only finished");
    endtask
    // Reset reopens every pair but leaves the array contents alone
    task automatic test_reset();
        @(negedge clk);
        arst_n = 1'h0;
        @(negedge clk);
        chk_flag("wr_ready", 1'h1, wrdy);
        chk_flag("rd_valid", 1'h0, rvo);
        arst_n = 1'h1;
        rd_chk(MASTER_DEBUG, 15'h0210, 32'h12345678, 1'h0);
        wr_chk(1'h0, 15'h0210, 32'h00005678, 1'h0);
        rd_chk(MASTER_DATA, 15'h0210, 32'h00005678, 1'h0);
        $display("test reset finished");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(negedge clk);
        arst_n = 1'h1;
        test_erase();
        test_program();
        test_read_only();
        test_exec_only();
        test_reset();
        conclude();
    end
endmodule // tb
`default_nettype wire
